// ---- common/dma_prog_pkg.sv ----
// shared constants and types for the dma host programming port
package dma_prog_pkg;
  localparam int NUM_CH = 4;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_WIDTH = 8;
  // port offsets with address bit 3 high
  localparam logic [3:0] PORT_STATUS_CMD = 4'h8;
  localparam logic [3:0] PORT_REQUEST = 4'h9;
  localparam logic [3:0] PORT_CMDRD_MASK1 = 4'hA;
  localparam logic [3:0] PORT_MODE = 4'hB;
  localparam logic [3:0] PORT_TOGGLE = 4'hC;
  localparam logic [3:0] PORT_TEMP_CLEAR = 4'hD;
  localparam logic [3:0] PORT_MODECNT_UNMASK = 4'hE;
  localparam logic [3:0] PORT_ALLMASK = 4'hF;
  // field positions
  localparam int CMD_DISABLE_BIT = 2;
  localparam int SEL_SETBIT = 2;
  localparam int MODE_DIR_LSB = 2;
  localparam int MODE_AUTOINIT_BIT = 4;
  localparam int MODE_DOWN_BIT = 5;
  // values after reset or master clear, and fill bits for reads
  localparam logic [7:0] CMD_RESET = 8'h00;
  localparam logic [3:0] MASK_RESET = 4'hF;
  localparam logic [3:0] REQ_RESET = 4'h0;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] TEMP_RESET = 8'h00;
  localparam logic [3:0] READ_FILL = 4'hF;
  localparam logic [1:0] MODE_READ_LOW = 2'h3;
  // transfer directions held in the mode register, and the count value of the last transfer
  localparam logic [1:0] DIR_TO_MEM = 2'h1;
  localparam logic [1:0] DIR_FROM_MEM = 2'h2;
  localparam logic [15:0] COUNT_LAST = 16'h0000;

  // host access pins sampled in one cycle
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic [3:0] addr;
    logic [7:0] data;
  } host_access_t;

  // bus strobes driven during a transfer
  typedef struct packed {
    logic io_rd;
    logic io_wr;
    logic mem_rd;
    logic mem_wr;
  } xfer_strobes_t;
endpackage

// ---- hw/dma_host_program_port.sv ----
// dma host programming port, command decode, hold handshake and transfer fifo
// Contract
// (RULE1) host access only after grant low one edge
// (RULE2) host never programs while granting the bus
// (RULE3) command bit 2 disables the controller
// (RULE4) enabled unmasked request served mid-programming
// (RULE5) host masks or disables before reprogramming
// (RULE6) commands act on access, data ignored
// (RULE7) read decode of ports eight to fifteen
// (RULE8) write decode of ports eight to fifteen
// (RULE9) host clears byte toggle before word access
// (RULE10) set toggle selects high byte first
// (RULE11) master clear resets registers, masks all
// (RULE12) clear-mask command unmasks all four channels
// (RULE13) two-bit counter picks mode register read
// (RULE14) mode reads run channel zero to three
// (RULE15) mode readback low two bits are ones
// (RULE16) request raises hold, bus waits for grant
// (RULE17) io/mem strobe pairs per transfer direction
// (RULE18) low ports select channel address or count
// (RULE19) toggle picks low or high byte
// (RULE20) base copies loaded together, never read
// (RULE21) mode write data bits pick channel
// (RULE22) toggle flips after each word byte access
// (RULE23) hardware reset equals master clear
`timescale 1ns/1ns

module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and control
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_flush,
  // fill side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  // drain side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic push;
  logic pop;

  // structure check
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("fifo depth must be a power of two, at least two");
  end

  // full and empty from pointer compare
  assign o_out_valid = (wr_q != rd_q);
  assign o_in_ready = (wr_q != {~rd_q[AW], rd_q[AW-1:0]});
  assign o_out_data = mem_q[rd_q[AW-1:0]];
  assign push = i_in_valid && o_in_ready;
  assign pop = i_out_ready && o_out_valid;

  // storage
  always_ff @(posedge i_clk) begin
    if (i_ce && push) begin
      mem_q[wr_q[AW-1:0]] <= i_in_data;
    end
  end

  // pointers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else if (i_ce) begin
      if (i_flush) begin
        wr_q <= '0;
        rd_q <= '0;
      end else begin
        if (push) begin
          wr_q <= wr_q + 1'b1;
        end
        if (pop) begin
          rd_q <= rd_q + 1'b1;
        end
      end
    end
  end
endmodule

module dma_host_program_port #(
  parameter int NUM_CH = dma_prog_pkg::NUM_CH,
  parameter int FIFO_DEPTH = dma_prog_pkg::FIFO_DEPTH
) (
  // clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // host programming bus
  input wire logic i_cs_n,
  input wire logic i_io_read_strobe_n,
  input wire logic i_io_write_strobe_n,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_data,
  output logic [7:0] o_data,
  output logic o_data_oe,
  // hold handshake
  output logic o_hold_request_out,
  input wire logic i_hold_grant,
  // peripheral requests
  input wire logic [3:0] i_channel_request_in,
  output logic [3:0] o_channel_ack,
  // system bus during transfers
  output logic [15:0] o_bus_addr,
  output logic o_bus_oe,
  output logic o_io_read_strobe,
  output logic o_io_write_strobe,
  output logic o_mem_read_strobe,
  output logic o_mem_write_strobe,
  input wire logic [7:0] i_bus_data,
  output logic o_capture_ready
);
  typedef enum logic [1:0] {ST_IDLE, ST_HOLD, ST_XFER} xfer_state_t;

  dma_prog_pkg::host_access_t acc;
  dma_prog_pkg::xfer_strobes_t strb_d;
  xfer_state_t state_q;
  logic grant_q;
  logic rd_prev_q;
  logic wr_prev_q;
  logic prog_ok;
  logic rd_go;
  logic wr_go;
  logic hi_port;
  logic clr;
  logic [7:0] cmd_q;
  logic [3:0] mask_q;
  logic [3:0] req_q;
  logic [3:0] tc_q;
  logic [3:0] pend_q;
  logic [7:0] temp_q;
  logic toggle_q;
  logic [1:0] mode_cnt_q;
  logic [5:0] mode_q [4];
  logic [15:0] base_addr_q [4];
  logic [15:0] cur_addr_q [4];
  logic [15:0] base_cnt_q [4];
  logic [15:0] cur_cnt_q [4];
  logic [1:0] ch_q;
  logic [1:0] lo_ch;
  logic [1:0] sel_ch;
  logic [3:0] want;
  logic word_acc;
  logic [15:0] word_rd;
  logic [7:0] rd_data;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic temp_pop;
  logic xfer_done;
  logic last_cnt;
  logic [7:0] act_mode;

  // parameter checks
  if (NUM_CH != 4) begin : g_bad_ch
    $error("channel count must be four");
  end

  // host access decode
  assign acc = '{cs_n: i_cs_n, rd_n: i_io_read_strobe_n, wr_n: i_io_write_strobe_n, addr: i_addr, data: i_data};
  assign prog_ok = !i_hold_grant && !grant_q; // [RULE1] [RULE2]
  assign rd_go = prog_ok && !acc.cs_n && !acc.rd_n && rd_prev_q;
  assign wr_go = prog_ok && !acc.cs_n && !acc.wr_n && wr_prev_q;
  assign hi_port = acc.addr[3];
  assign sel_ch = acc.addr[2:1]; // [RULE18]
  assign word_acc = (rd_go || wr_go) && !hi_port;
  assign clr = wr_go && acc.addr == dma_prog_pkg::PORT_TEMP_CLEAR; // [RULE6] [RULE8]
  assign temp_pop = rd_go && acc.addr == dma_prog_pkg::PORT_TEMP_CLEAR && fifo_out_valid;

  // grant history and strobe edges
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      grant_q <= 1'b0;
      rd_prev_q <= 1'b1;
      wr_prev_q <= 1'b1;
    end else if (i_ce) begin
      grant_q <= i_hold_grant;
      rd_prev_q <= acc.rd_n | acc.cs_n;
      wr_prev_q <= acc.wr_n | acc.cs_n;
    end
  end

  // read data mux
  always_comb begin
    word_rd = acc.addr[0] ? cur_cnt_q[sel_ch] : cur_addr_q[sel_ch]; // [RULE20]
    rd_data = toggle_q ? word_rd[15:8] : word_rd[7:0]; // [RULE19]
    if (hi_port) begin
      case (acc.addr) // [RULE7]
        dma_prog_pkg::PORT_STATUS_CMD: rd_data = {pend_q, tc_q};
        dma_prog_pkg::PORT_REQUEST: rd_data = {dma_prog_pkg::READ_FILL, req_q};
        dma_prog_pkg::PORT_CMDRD_MASK1: rd_data = cmd_q;
        dma_prog_pkg::PORT_MODE: rd_data = {mode_q[mode_cnt_q], dma_prog_pkg::MODE_READ_LOW}; // [RULE13] [RULE15]
        dma_prog_pkg::PORT_TEMP_CLEAR: rd_data = fifo_out_valid ? fifo_out_data : temp_q;
        dma_prog_pkg::PORT_ALLMASK: rd_data = {dma_prog_pkg::READ_FILL, mask_q};
        default: rd_data = 8'h00;
      endcase
    end
  end

  // read data register and drive enable
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_data <= 8'h00;
      o_data_oe <= 1'b0;
    end else if (i_ce) begin
      if (rd_go) begin
        o_data <= rd_data;
      end
      o_data_oe <= prog_ok && !acc.cs_n && !acc.rd_n;
    end
  end

  // command register
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cmd_q <= dma_prog_pkg::CMD_RESET; // [RULE23]
    end else if (i_ce) begin
      if (clr) begin
        cmd_q <= dma_prog_pkg::CMD_RESET; // [RULE11]
      end else if (wr_go && acc.addr == dma_prog_pkg::PORT_STATUS_CMD) begin
        cmd_q <= acc.data;
      end
    end
  end

  // mask bits, hardware sets on terminal count win over software clear
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      mask_q <= dma_prog_pkg::MASK_RESET;
    end else if (i_ce) begin
      if (clr) begin
        mask_q <= dma_prog_pkg::MASK_RESET; // [RULE11]
      end else begin
        if (wr_go && acc.addr == dma_prog_pkg::PORT_CMDRD_MASK1) begin
          mask_q[acc.data[1:0]] <= acc.data[dma_prog_pkg::SEL_SETBIT];
        end
        if (wr_go && acc.addr == dma_prog_pkg::PORT_MODECNT_UNMASK) begin
          mask_q <= 4'h0; // [RULE12]
        end
        if (wr_go && acc.addr == dma_prog_pkg::PORT_ALLMASK) begin
          mask_q <= acc.data[3:0];
        end
        if (xfer_done && last_cnt && !act_mode[dma_prog_pkg::MODE_AUTOINIT_BIT]) begin
          mask_q[ch_q] <= 1'b1;
        end
      end
    end
  end

  // software requests, cleared when their channel reaches terminal count
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      req_q <= dma_prog_pkg::REQ_RESET;
    end else if (i_ce) begin
      if (clr) begin
        req_q <= dma_prog_pkg::REQ_RESET;
      end else begin
        if (xfer_done && last_cnt) begin
          req_q[ch_q] <= 1'b0;
        end
        if (wr_go && acc.addr == dma_prog_pkg::PORT_REQUEST) begin
          req_q[acc.data[1:0]] <= acc.data[dma_prog_pkg::SEL_SETBIT];
        end
      end
    end
  end

  // status: terminal count flags clear on read, a new count wins
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      {pend_q, tc_q} <= dma_prog_pkg::STATUS_RESET;
    end else if (i_ce) begin
      if (clr) begin
        {pend_q, tc_q} <= dma_prog_pkg::STATUS_RESET;
      end else begin
        pend_q <= i_channel_request_in;
        if (rd_go && acc.addr == dma_prog_pkg::PORT_STATUS_CMD) begin
          tc_q <= 4'h0;
        end
        if (xfer_done && last_cnt) begin
          tc_q[ch_q] <= 1'b1;
        end
      end
    end
  end

  // byte toggle and mode readback counter
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      toggle_q <= 1'b0;
      mode_cnt_q <= 2'h0;
    end else if (i_ce) begin
      if (clr) begin
        toggle_q <= 1'b0;
        mode_cnt_q <= 2'h0;
      end else begin
        if (wr_go && acc.addr == dma_prog_pkg::PORT_TOGGLE) begin
          toggle_q <= 1'b0;
        end else if (rd_go && acc.addr == dma_prog_pkg::PORT_TOGGLE) begin
          toggle_q <= 1'b1; // [RULE10]
        end else if (word_acc) begin
          toggle_q <= !toggle_q; // [RULE22]
        end
        if (rd_go && acc.addr == dma_prog_pkg::PORT_MODECNT_UNMASK) begin
          mode_cnt_q <= 2'h0; // [RULE14]
        end else if (rd_go && acc.addr == dma_prog_pkg::PORT_MODE) begin
          mode_cnt_q <= mode_cnt_q + 2'h1; // [RULE13]
        end
      end
    end
  end

  // mode registers
  always_ff @(posedge i_clk) begin
    if (i_ce && wr_go && acc.addr == dma_prog_pkg::PORT_MODE) begin
      mode_q[acc.data[1:0]] <= acc.data[7:2]; // [RULE21]
    end
  end

  // channel address and count words, host load or transfer update
  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      if (wr_go && !hi_port) begin
        if (acc.addr[0]) begin
          if (toggle_q) begin
            base_cnt_q[sel_ch][15:8] <= acc.data; // [RULE20]
            cur_cnt_q[sel_ch][15:8] <= acc.data;
          end else begin
            base_cnt_q[sel_ch][7:0] <= acc.data;
            cur_cnt_q[sel_ch][7:0] <= acc.data;
          end
        end else begin
          if (toggle_q) begin
            base_addr_q[sel_ch][15:8] <= acc.data; // [RULE18]
            cur_addr_q[sel_ch][15:8] <= acc.data;
          end else begin
            base_addr_q[sel_ch][7:0] <= acc.data;
            cur_addr_q[sel_ch][7:0] <= acc.data;
          end
        end
      end else if (xfer_done) begin
        if (last_cnt && act_mode[dma_prog_pkg::MODE_AUTOINIT_BIT]) begin
          cur_addr_q[ch_q] <= base_addr_q[ch_q];
          cur_cnt_q[ch_q] <= base_cnt_q[ch_q];
        end else begin
          cur_cnt_q[ch_q] <= cur_cnt_q[ch_q] - 16'h0001;
          if (act_mode[dma_prog_pkg::MODE_DOWN_BIT]) begin
            cur_addr_q[ch_q] <= cur_addr_q[ch_q] - 16'h0001;
          end else begin
            cur_addr_q[ch_q] <= cur_addr_q[ch_q] + 16'h0001;
          end
        end
      end
    end
  end

  // request arbitration, lowest channel first
  assign want = (i_channel_request_in & ~mask_q) | req_q; // [RULE4]
  always_comb begin
    lo_ch = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (want[i]) begin
        lo_ch = 2'(i);
      end
    end
  end
  assign last_cnt = (cur_cnt_q[ch_q] == dma_prog_pkg::COUNT_LAST);
  assign xfer_done = (state_q == ST_XFER) && fifo_in_ready;
  // active mode rebuilt as the written byte, so field positions hold
  assign act_mode = {mode_q[ch_q], dma_prog_pkg::MODE_READ_LOW};

  // transfer sequencer
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= ST_IDLE;
      ch_q <= 2'h0;
    end else if (i_ce) begin
      if (clr) begin
        state_q <= ST_IDLE; // [RULE11]
      end else begin
        case (state_q)
          ST_IDLE: begin
            if (!cmd_q[dma_prog_pkg::CMD_DISABLE_BIT] && want != 4'h0) begin // [RULE3]
              state_q <= ST_HOLD;
              ch_q <= lo_ch;
            end
          end
          ST_HOLD: begin
            if (i_hold_grant) begin
              state_q <= ST_XFER; // [RULE16]
            end
          end
          ST_XFER: begin
            if (fifo_in_ready) begin
              state_q <= ST_IDLE;
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // strobe pairs per direction
  always_comb begin
    strb_d = '0;
    if (state_q == ST_XFER || (state_q == ST_HOLD && i_hold_grant)) begin
      case (act_mode[dma_prog_pkg::MODE_DIR_LSB +: 2]) // [RULE17]
        dma_prog_pkg::DIR_TO_MEM: begin
          strb_d.io_rd = 1'b1;
          strb_d.mem_wr = 1'b1;
        end
        dma_prog_pkg::DIR_FROM_MEM: begin
          strb_d.mem_rd = 1'b1;
          strb_d.io_wr = 1'b1;
        end
        default: strb_d = '0;
      endcase
    end
  end

  // bus outputs registered, driven only after grant
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_hold_request_out <= 1'b0;
      o_bus_oe <= 1'b0;
      o_bus_addr <= 16'h0000;
      o_channel_ack <= 4'h0;
      {o_io_read_strobe, o_io_write_strobe, o_mem_read_strobe, o_mem_write_strobe} <= 4'h0;
    end else if (i_ce) begin
      if (clr || (state_q == ST_XFER && fifo_in_ready)) begin
        o_hold_request_out <= 1'b0;
        o_bus_oe <= 1'b0;
        o_channel_ack <= 4'h0;
        {o_io_read_strobe, o_io_write_strobe, o_mem_read_strobe, o_mem_write_strobe} <= 4'h0;
      end else begin
        o_hold_request_out <= (state_q != ST_IDLE) ||
                              (!cmd_q[dma_prog_pkg::CMD_DISABLE_BIT] && want != 4'h0); // [RULE16]
        o_bus_oe <= i_hold_grant && state_q != ST_IDLE;
        o_bus_addr <= cur_addr_q[ch_q];
        o_channel_ack <= (i_hold_grant && state_q != ST_IDLE) ? (4'h1 << ch_q) : 4'h0;
        {o_io_read_strobe, o_io_write_strobe, o_mem_read_strobe, o_mem_write_strobe} <= strb_d;
      end
    end
  end

  // capture ready shown to the bus side
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_capture_ready <= 1'b1;
    end else if (i_ce) begin
      o_capture_ready <= fifo_in_ready;
    end
  end

  // last popped byte kept as temporary data
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      temp_q <= dma_prog_pkg::TEMP_RESET;
    end else if (i_ce) begin
      if (clr) begin
        temp_q <= dma_prog_pkg::TEMP_RESET; // [RULE11]
      end else if (temp_pop) begin
        temp_q <= fifo_out_data;
      end
    end
  end

  // moved bytes queue, drained by temporary-data reads
  byte_fifo #(
    .WIDTH(dma_prog_pkg::FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_moved (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_flush(clr),
    .i_in_valid(state_q == ST_XFER),
    .o_in_ready(fifo_in_ready),
    .i_in_data(i_bus_data),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(temp_pop),
    .o_out_data(fifo_out_data)
  );
endmodule

// ---- testbench/dma_host_program_port_properties.sv ----
// pin-level assertions for the dma host programming port
`timescale 1ns/1ns
module dma_host_program_port_checker (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // host side
  input wire logic i_cs_n,
  input wire logic i_io_read_strobe_n,
  input wire logic o_data_oe,
  // hold and transfer side
  input wire logic i_hold_grant,
  input wire logic o_hold_request_out,
  input wire logic [3:0] o_channel_ack,
  input wire logic o_bus_oe,
  input wire logic o_io_read_strobe,
  input wire logic o_io_write_strobe,
  input wire logic o_mem_read_strobe,
  input wire logic o_mem_write_strobe,
  input wire logic o_capture_ready
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // host reads only answered well clear of a grant
  a_prog_blocked: assert property ((i_hold_grant || $past(i_hold_grant)) |=> !o_data_oe)
    else $error("host read answered near a grant");
  a_oe_cause: assert property ($rose(o_data_oe) |-> !$past(i_cs_n) && !$past(i_io_read_strobe_n))
    else $error("read enable without a host read");
  // bus ownership follows the grant
  a_bus_after_grant: assert property (!i_hold_grant |=> !o_bus_oe)
    else $error("bus driven without grant");
  a_rise_on_grant: assert property ($rose(o_bus_oe) |-> $past(i_hold_grant) && o_hold_request_out)
    else $error("bus taken without hold handshake");
  a_xfer_follows: assert property ($rose(i_hold_grant) && o_hold_request_out |-> ##[1:4] o_bus_oe)
    else $error("granted transfer never started");
  a_hold_drop: assert property ($fell(o_hold_request_out) |-> !o_bus_oe && !o_io_read_strobe && !o_mem_read_strobe)
    else $error("bus kept after hold dropped");
  a_strobe_owns: assert property ((o_io_read_strobe || o_mem_read_strobe) |-> o_bus_oe && $onehot(o_channel_ack))
    else $error("strobe without bus ownership");
  // strobe pairs per direction
  a_io_pair: assert property (o_io_read_strobe |-> o_mem_write_strobe && !o_mem_read_strobe && !o_io_write_strobe)
    else $error("io read not paired with memory write");
  a_mem_pair: assert property (o_mem_read_strobe |-> o_io_write_strobe && !o_io_read_strobe && !o_mem_write_strobe)
    else $error("memory read not paired with io write");
  // quiet pins right after reset
  a_reset_quiet: assert property ($past(i_rst) |-> !o_hold_request_out && !o_bus_oe && o_capture_ready)
    else $error("outputs not at reset values");
endmodule

bind dma_host_program_port dma_host_program_port_checker i_chk (.i_clk, .i_rst, .i_cs_n, .i_io_read_strobe_n,
  .o_data_oe, .i_hold_grant, .o_hold_request_out, .o_channel_ack, .o_bus_oe, .o_io_read_strobe,
  .o_io_write_strobe, .o_mem_read_strobe, .o_mem_write_strobe, .o_capture_ready);

// ---- testbench/host_bus_model.sv ----
// host processor side: grants the system bus after a set delay
`timescale 1ns/1ns
module host_bus_model (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // hold handshake
  input wire logic i_hold_request_out,
  input wire logic [3:0] i_delay,
  output logic o_hold_grant
);
  logic [3:0] wait_q;

  // grant only while the host is off its bus, drop once hold goes away
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wait_q <= 4'h0;
      o_hold_grant <= 1'h0;
    end else if (!i_hold_request_out) begin
      wait_q <= 4'h0;
      o_hold_grant <= 1'h0;
    end else if (wait_q >= i_delay) begin
      o_hold_grant <= 1'h1;
    end else begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule

// ---- testbench/dma_host_program_port_tb.sv ----
// self-checking bench of the dma host programming port
`timescale 1ns/1ns
`define CHK(g, w) begin samples_checked++; if ((g) !== (w)) begin n_errors++; \
  $display("unexpected at %0t: %h not %h", $time, (g), (w)); end end
module dma_host_program_port_tb;
  logic i_clk, i_rst, cs_n, rd_n, wr_n, grant, oe, hreq, boe, iord, iowr, mrd, mwr, cap, tog;
  logic [3:0] addr, creq, dly, ack, mask, req;
  logic [7:0] data, q, bdat, odat, cmd, tmp;
  logic [15:0] baddr;
  logic [15:0] wreg [8];
  logic [5:0] mode [4];
  logic [7:0] tq [$];
  int mcnt, n_errors, samples_checked, i, c;
  integer seed;

  // design and host bus grantor
  dma_host_program_port i_dma_host_program_port (
    .i_clk(i_clk), .i_rst(i_rst), .i_ce(1'h1), .i_cs_n(cs_n), .i_io_read_strobe_n(rd_n),
    .i_io_write_strobe_n(wr_n), .i_addr(addr), .i_data(data), .o_data(odat), .o_data_oe(oe),
    .o_hold_request_out(hreq), .i_hold_grant(grant), .i_channel_request_in(creq), .o_channel_ack(ack),
    .o_bus_addr(baddr), .o_bus_oe(boe), .o_io_read_strobe(iord), .o_io_write_strobe(iowr),
    .o_mem_read_strobe(mrd), .o_mem_write_strobe(mwr), .i_bus_data(bdat), .o_capture_ready(cap));
  host_bus_model i_host_bus_model (.i_clk(i_clk), .i_rst(i_rst), .i_hold_request_out(hreq),
    .i_delay(dly), .o_hold_grant(grant));

  // verdict and end of run
  task automatic stop_test;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // model state after master clear
  task automatic mclr;
    cmd = 8'h00;
    mask = 4'hF;
    req = 4'h0;
    tog = 1'h0;
    mcnt = 0;
    tmp = 8'h00;
    tq.delete();
  endtask

  task automatic hw_reset;
    i_rst = 1'h1;
    repeat (4) @(negedge i_clk);
    i_rst = 1'h0;
    mclr();
  endtask

  // one host access, only while the bus is ours
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
    do @(negedge i_clk); while (grant || hreq);
    @(negedge i_clk);
    cs_n = 1'h0;
    addr = a;
    data = d;
    wr_n = !w;
    rd_n = w;
    repeat (2) @(negedge i_clk);
    q = odat;
    {cs_n, rd_n, wr_n} = 3'h7;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    acc(1'h1, a, d);
    if (!a[3]) begin
      if (tog) wreg[a[2:0]][15:8] = d;
      else wreg[a[2:0]][7:0] = d;
      tog = !tog;
    end
    case (a)
      4'h8: cmd = d;
      4'h9: req[d[1:0]] = d[2];
      4'hA: mask[d[1:0]] = d[2];
      4'hB: mode[d[1:0]] = d[7:2];
      4'hC: tog = 1'h0;
      4'hD: mclr();
      4'hE: mask = 4'h0;
      4'hF: mask = d[3:0];
      default: ;
    endcase
  endtask

  task automatic rd(input logic [3:0] a);
    logic [7:0] e;
    e = 8'h00;
    if (!a[3]) begin
      e = tog ? wreg[a[2:0]][15:8] : wreg[a[2:0]][7:0];
      tog = !tog;
    end
    case (a)
      4'h9: e = {4'hF, req};
      4'hA: e = cmd;
      4'hB: e = {mode[mcnt], 2'h3};
      4'hD: begin
        if (tq.size() > 0) tmp = tq.pop_front();
        e = tmp;
      end
      4'hF: e = {4'hF, mask};
      default: ;
    endcase
    acc(1'h0, a, 8'($random(seed)));
    if (a == 4'hB) mcnt = (mcnt + 1) % 4;
    if (a == 4'hC) tog = 1'h1;
    if (a == 4'hE) mcnt = 0;
    if (a != 4'hC && a != 4'hE) `CHK(q, e)
  endtask

  // one byte moved for channel c, peripheral byte queued
  task automatic xfer(input int c);
    logic [3:0] e;
    e = (mode[c][1:0] == 2'h1) ? 4'hC : 4'h3;
    bdat = 8'($random(seed));
    dly = 4'($random(seed)) & 4'h7;
    tq.push_back(bdat);
    creq[c] = 1'h1;
    do @(negedge i_clk); while (!boe);
    `CHK(baddr, wreg[2 * c])
    `CHK({iord, mwr, mrd, iowr}, e)
    `CHK(ack, 4'h1 << c)
    creq[c] = 1'h0;
    do @(negedge i_clk); while (hreq);
    bdat = ~bdat;
    wreg[2 * c] = mode[c][3] ? wreg[2 * c] - 16'h0001 : wreg[2 * c] + 16'h0001;
    wreg[2 * c + 1] = wreg[2 * c + 1] - 16'h0001;
  endtask

  task automatic rst_chk;
    rd(4'h8);
    rd(4'h9);
    rd(4'hA);
    rd(4'hD);
    rd(4'hF);
  endtask

  // clock
  initial begin
    i_clk = 1'h0;
    forever #5 i_clk = ~i_clk;
  end

  // watchdog
  initial begin
    repeat (20000) @(posedge i_clk);
    n_errors++;
    stop_test();
  end

  // main sequence
  initial begin
    {i_rst, cs_n, rd_n, wr_n} = 4'hF;
    addr = 4'h0;
    data = 8'h00;
    creq = 4'h0;
    dly = 4'h0;
    bdat = 8'h00;
    seed = 16068;
    n_errors = 0;
    samples_checked = 0;
    hw_reset();
    rst_chk();
    wr(4'h8, 8'($random(seed)) | 8'h04);
    rd(4'hA);
    for (c = 0; c < 4; c++) begin
      wr(4'h9, 8'(c + 4));
      rd(4'h9);
      wr(4'hA, 8'(c));
      rd(4'hF);
    end
    `CHK(hreq, 1'h0)
    wr(4'hF, 8'($random(seed)));
    rd(4'hF);
    wr(4'hE, 8'($random(seed)));
    rd(4'hF);
    wr(4'hC, 8'($random(seed)));
    for (i = 0; i < 12; i++) wr(4'(i / 2), 8'($random(seed)));
    for (i = 0; i < 12; i++) rd(4'(i / 2));
    rd(4'hC);
    rd(4'h0);
    for (c = 0; c < 4; c++) wr(4'hB, {6'($random(seed)), 2'(c)});
    rd(4'hE);
    for (c = 0; c < 5; c++) rd(4'hB);
    wr(4'hD, 8'($random(seed)));
    rst_chk();
    rd(4'hB);
    rd(4'h0);
    wr(4'hB, 8'h65);
    wr(4'hB, 8'h4A);
    wr(4'hC, 8'h00);
    wr(4'h3, 8'($random(seed)));
    wr(4'h3, 8'h01);
    creq = 4'h2;
    repeat (20) @(negedge i_clk);
    `CHK(hreq, 1'h0)
    wr(4'h8, 8'h04);
    wr(4'hE, 8'h00);
    repeat (20) @(negedge i_clk);
    `CHK(hreq, 1'h0)
    wr(4'h2, 8'($random(seed)));
    wr(4'h8, 8'h00);
    xfer(1);
    for (i = 0; i < 14; i++) xfer(1);
    xfer(2);
    @(negedge i_clk);
    `CHK(cap, 1'h0)
    for (i = 0; i < 16; i++) rd(4'hD);
    @(negedge i_clk);
    `CHK(cap, 1'h1)
    wr(4'hC, 8'h00);
    for (i = 0; i < 4; i++) rd(4'(2 + i / 2));
    hw_reset();
    rst_chk();
    stop_test();
  end
endmodule
